/* File: charge_cycle_ctrl.sv */
// Charge cycle controller with APB register slave
`timescale 1ns/100ps
module charge_cycle_ctrl
  import charge_pkg::*;
#(
  parameter logic [63:0] SAFETY_STEP = SAFETY_STEP_CYC,
  parameter logic [63:0] WDOG_MIN_LEN = WDOG_MIN_CYC,
  parameter logic [63:0] WDOG_NOM_LEN = WDOG_NOM_CYC,
  parameter int OVP_DGL_LEN = OVP_DGL_CYC,
  parameter logic [31:0] THERM_ON_LEN = 32'(THERM_ON_CYC),
  parameter logic [31:0] THERM_OFF_LEN = 32'(THERM_OFF_CYC),
  parameter logic [31:0] IDLE_RST_LEN = 32'(IDLE_RST_CYC),
  parameter logic [31:0] OCP_REC_LEN = 32'(OCP_REC_CYC)
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic vin_valid,
  input wire logic vin_ovp,
  input wire logic thermistor_ok,
  input wire logic thermistor_in_window,
  input wire logic vbat_below_short,
  input wire logic vbat_below_exit,
  input wire logic vbat_below_recharge,
  input wire logic vbat_below_uvlo,
  input wire logic cur_at_termination,
  input wire logic cv_loop_active,
  input wire logic vin_dyn_active,
  input wire logic path_dyn_active,
  input wire logic thermal_reg_active,
  input wire logic supplement_req,
  input wire logic bat_overcurrent,
  output logic battery_switch_on,
  output logic [9:0] charge_current,
  output logic [12:0] vreg_applied,
  output logic [2:0] charge_state,
  output logic charge_done,
  output logic safety_fault,
  output logic therm_bias_on,
  output logic iface_reset
);
  // ==========================================================================
  // Functions
  function automatic logic [63:0] safety_limit(input logic [1:0] sel,
                                               input logic [63:0] step);
    return step * ({62'd0, sel} + 64'd1);
  endfunction

  function automatic chg_state_t phase_of(input logic below_short,
                                          input logic below_exit);
    if (below_short) begin
      return ST_TRICKLE;
    end else if (below_exit) begin
      return ST_PRE;
    end
    return ST_FAST;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a, input logic wr);
    logic rw;
    rw = (a == CTRL_OFS) || (a == FAST_CUR_OFS) || (a == PRE_CUR_OFS) ||
         (a == VREG_OFS);
    return rw || (!wr && (a == STATUS_OFS || a == APPLIED_OFS));
  endfunction

  function automatic logic is_charging(input chg_state_t s);
    return s == ST_TRICKLE || s == ST_PRE || s == ST_FAST;
  endfunction

  // ==========================================================================
  // Registers and state
  logic inhibit_q, term_dis_q;
  logic [1:0] wdog_sel_q, safety_sel_q;
  logic [9:0] fast_cur_q, pre_cur_q;
  logic [12:0] vreg_q;
  chg_state_t state_q, state_d;
  logic [63:0] safety_cnt_q, wdog_cnt_q;
  logic [31:0] therm_cnt_q, idle_cnt_q, ocp_cnt_q;
  logic done_flag_q, fault_q, ovp_q, ocp_hold_q, bsw_q, therm_q;
  logic wdog_fire, idle_fire, iface_rst_q;
  logic [9:0] cur_q;
  logic [12:0] vreg_app_q;
  logic [31:0] prdata_q;
  logic sleep_flag, uvlo_flag, vin_ok, bat_only, allowed, terminate;
  logic timeout, supplement, bsw_d, apb_wr, apb_acc;
  logic [63:0] limit;

  dgl_if sleep_dg();
  dgl_if ovp_dg();
  dgl_if uvlo_dg();

  // ==========================================================================
  // Deglitch timers
  assign sleep_dg.cond = !vin_valid;
  assign ovp_dg.cond = !vin_ovp;
  assign uvlo_dg.cond = vbat_below_uvlo;
  assign sleep_flag = sleep_dg.done;
  assign uvlo_flag = uvlo_dg.done;

  hold_timer #(.CYC(SLEEP_DGL_CYC)) sleep_tmr (
    .mclk(mclk),
    .reset(reset),
    .dg(sleep_dg)
  );

  hold_timer #(.CYC(OVP_DGL_LEN)) ovp_tmr (
    .mclk(mclk),
    .reset(reset),
    .dg(ovp_dg)
  );

  hold_timer #(.CYC(UVLO_DGL_CYC)) uvlo_tmr (
    .mclk(mclk),
    .reset(reset),
    .dg(uvlo_dg)
  );

  // Overvoltage sets at once, clears only after the deglitched fall
  always_ff @(posedge mclk) begin
    if (reset) begin
      ovp_q <= 1'b0;
    end else if (vin_ovp) begin
      ovp_q <= 1'b1;
    end else if (ovp_dg.done) begin
      ovp_q <= 1'b0;
    end
  end

  assign vin_ok = vin_valid && !ovp_q;
  assign bat_only = !vin_ok;

  // ==========================================================================
  // APB slave: zero wait states
  assign pready = 1'b1;
  assign apb_acc = psel && penable;
  assign apb_wr = apb_acc && pwrite && is_mapped(paddr, 1'b1);
  assign pslverr = apb_acc && !is_mapped(paddr, pwrite);
  assign prdata = prdata_q;

  always_ff @(posedge mclk) begin
    if (reset || wdog_fire) begin
      inhibit_q <= 1'b0;
      term_dis_q <= 1'b0;
      wdog_sel_q <= WDOG_RST;
      safety_sel_q <= SAFETY_RST;
      fast_cur_q <= FAST_CUR_RST;
      pre_cur_q <= PRE_CUR_RST;
      vreg_q <= VREG_RST;
    end else if (apb_wr) begin
      unique case (paddr)
        CTRL_OFS: begin
          inhibit_q <= pwdata[CTRL_INHIBIT_BIT];
          term_dis_q <= pwdata[CTRL_TERM_DIS_BIT];
          wdog_sel_q <= pwdata[CTRL_WDOG_LSB +: 2];
          safety_sel_q <= pwdata[CTRL_SAFETY_LSB +: 2];
        end
        FAST_CUR_OFS: fast_cur_q <= pwdata[9:0];
        PRE_CUR_OFS: pre_cur_q <= pwdata[9:0];
        default: vreg_q <= pwdata[12:0];
      endcase
    end
  end

  // Read data is captured in the setup cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      prdata_q <= '0;
    end else if (psel && !penable) begin
      prdata_q <= '0;
      unique case (paddr)
        CTRL_OFS: prdata_q[5:0] <= {safety_sel_q, wdog_sel_q, term_dis_q,
                                    inhibit_q};
        FAST_CUR_OFS: prdata_q[9:0] <= fast_cur_q;
        PRE_CUR_OFS: prdata_q[9:0] <= pre_cur_q;
        VREG_OFS: prdata_q[12:0] <= vreg_q;
        STATUS_OFS: prdata_q[10:0] <= {bsw_q, supplement, ocp_hold_q,
                                       uvlo_flag, ovp_q, sleep_flag,
                                       fault_q, done_flag_q, state_q};
        APPLIED_OFS: prdata_q <= {3'd0, vreg_app_q, 6'd0, cur_q};
        default: prdata_q <= '0;
      endcase
    end
  end

  // ==========================================================================
  // Host watchdog and inactivity reset
  always_ff @(posedge mclk) begin
    if (reset || apb_acc || wdog_sel_q == WDOG_OFF || wdog_fire) begin
      wdog_cnt_q <= '0;
    end else begin
      wdog_cnt_q <= wdog_cnt_q + 64'd1;
    end
  end

  assign wdog_fire = !apb_acc && ((wdog_sel_q == WDOG_MIN &&
                     wdog_cnt_q == WDOG_MIN_LEN - 64'd1) ||
                     (wdog_sel_q == WDOG_NOM &&
                     wdog_cnt_q == WDOG_NOM_LEN - 64'd1));

  always_ff @(posedge mclk) begin
    if (reset || psel || idle_fire) begin
      idle_cnt_q <= '0;
    end else begin
      idle_cnt_q <= idle_cnt_q + 32'd1;
    end
  end

  assign idle_fire = !psel && idle_cnt_q == IDLE_RST_LEN - 32'd1;

  always_ff @(posedge mclk) begin
    if (reset) begin
      iface_rst_q <= 1'b0;
    end else begin
      iface_rst_q <= wdog_fire || idle_fire;
    end
  end

  // ==========================================================================
  // Charge sequencing
  assign allowed = vin_ok && !inhibit_q && thermistor_ok;
  assign limit = (state_q == ST_FAST) ? safety_limit(safety_sel_q,
                 SAFETY_STEP) : safety_limit(safety_sel_q, SAFETY_STEP) >> 2;
  assign timeout = is_charging(state_q) &&
                   safety_cnt_q >= limit - 64'd1;
  assign terminate = cur_at_termination && cv_loop_active &&
                     !vin_dyn_active && !path_dyn_active &&
                     !thermal_reg_active && !term_dis_q && !supplement_req;

  always_comb begin
    state_d = state_q;
    if (!allowed) begin
      state_d = ST_IDLE;
    end else if (timeout) begin
      state_d = ST_FAULT;
    end else begin
      unique case (state_q)
        ST_IDLE: state_d = phase_of(vbat_below_short, vbat_below_exit);
        ST_TRICKLE, ST_PRE:
          state_d = phase_of(vbat_below_short, vbat_below_exit);
        ST_FAST: if (terminate) state_d = ST_DONE;
        ST_DONE: if (vbat_below_recharge) begin
          state_d = phase_of(vbat_below_short, vbat_below_exit);
        end
        ST_FAULT: state_d = ST_FAULT;
        default: state_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Shared precharge interval; restarted on cycle start and fast entry
  always_ff @(posedge mclk) begin
    if (reset || !is_charging(state_d)) begin
      safety_cnt_q <= '0;
    end else if (!is_charging(state_q) ||
                 (state_d == ST_FAST && state_q != ST_FAST)) begin
      safety_cnt_q <= '0;
    end else begin
      safety_cnt_q <= safety_cnt_q + 64'd1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      done_flag_q <= 1'b0;
      fault_q <= 1'b0;
    end else if (state_q == ST_FAST && state_d == ST_DONE) begin
      done_flag_q <= 1'b1;
    end else if (state_d == ST_FAULT) begin
      fault_q <= 1'b1;
    end else if (is_charging(state_d) && !is_charging(state_q)) begin
      done_flag_q <= 1'b0;
      fault_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Current and voltage targets for the analog loops
  always_ff @(posedge mclk) begin
    if (reset) begin
      cur_q <= '0;
      vreg_app_q <= VREG_RST;
    end else begin
      unique case (state_d)
        ST_TRICKLE: cur_q <= TRICKLE_CUR;
        ST_PRE: cur_q <= term_dis_q ? fast_cur_q / CUR_DIV :
                         pre_cur_q;
        ST_FAST: cur_q <= fast_cur_q;
        default: cur_q <= '0;
      endcase
      vreg_app_q <= (vreg_q > VREG_MAX_MV) ? VREG_MAX_MV : vreg_q;
    end
  end

  // ==========================================================================
  // Battery switch, overcurrent recovery, thermistor bias
  always_ff @(posedge mclk) begin
    if (reset) begin
      ocp_hold_q <= 1'b0;
      ocp_cnt_q <= '0;
    end else if (bat_overcurrent && !is_charging(state_q)) begin
      ocp_hold_q <= 1'b1;
      ocp_cnt_q <= '0;
    end else if (ocp_hold_q) begin
      ocp_cnt_q <= ocp_cnt_q + 32'd1;
      if (ocp_cnt_q == OCP_REC_LEN - 32'd1) begin
        ocp_hold_q <= 1'b0;
      end
    end
  end

  // Supplement does not look at the inhibit bit
  assign supplement = supplement_req && !uvlo_flag && !ocp_hold_q;
  assign bsw_d = is_charging(state_d) ||
                 ((supplement_req || bat_only) && !uvlo_flag &&
                 !ocp_hold_q);

  always_ff @(posedge mclk) begin
    if (reset) begin
      bsw_q <= 1'b0;
    end else begin
      bsw_q <= bsw_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || !bat_only ||
        therm_cnt_q == THERM_ON_LEN + THERM_OFF_LEN - 32'd1) begin
      therm_cnt_q <= '0;
    end else begin
      therm_cnt_q <= therm_cnt_q + 32'd1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      therm_q <= 1'b1;
    end else begin
      therm_q <= !bat_only || therm_cnt_q < THERM_ON_LEN;
    end
  end

  assign battery_switch_on = bsw_q;
  assign charge_current = cur_q;
  assign vreg_applied = vreg_app_q;
  assign charge_state = state_q;
  assign charge_done = done_flag_q;
  assign safety_fault = fault_q;
  assign therm_bias_on = therm_q;
  assign iface_reset = iface_rst_q;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  start_gate_a: assert property (
    state_q == ST_IDLE && !allowed |=> state_q == ST_IDLE)
    else $error("charge started while not allowed");
  inhibit_off_a: assert property (
    inhibit_q && thermistor_in_window && vin_ok && !supplement_req
    |=> !battery_switch_on)
    else $error("battery switch on under inhibit");
  trickle_cur_a: assert property (
    state_q == ST_TRICKLE |-> charge_current == TRICKLE_CUR)
    else $error("trickle current wrong");
  pre_fifth_a: assert property (
    state_q == ST_PRE && $past(term_dis_q)
    |-> charge_current == $past(fast_cur_q) / CUR_DIV)
    else $error("precharge current not one fifth");
  vreg_clamp_a: assert property (
    ##1 vreg_applied <= VREG_MAX_MV &&
    (vreg_applied == $past(vreg_q) || $past(vreg_q) > VREG_MAX_MV))
    else $error("regulation target not clamped");
  done_switch_a: assert property (
    state_q == ST_DONE && !supplement_req && vin_ok && !vbat_below_recharge
    |-> ##1 !battery_switch_on)
    else $error("battery switch on after termination");
  term_block_a: assert property (
    state_q == ST_FAST && (vin_dyn_active || path_dyn_active ||
    thermal_reg_active || !cv_loop_active) |=> state_q != ST_DONE)
    else $error("termination under loop limitation");
  recharge_a: assert property (
    state_q == ST_DONE && vbat_below_recharge && allowed
    |=> is_charging(state_q) && safety_cnt_q == 64'd0 ##1 charge_done == 1'b0)
    else $error("recharge did not restart cycle");
  timeout_a: assert property (
    timeout && allowed |=> state_q == ST_FAULT && safety_fault ##1 safety_fault)
    else $error("safety timeout not handled");
  ocp_wait_a: assert property (
    $rose(ocp_hold_q) |=> !battery_switch_on [*8])
    else $error("battery reconnected during recovery");
  wdog_reset_a: assert property (
    wdog_fire |=> iface_reset && wdog_sel_q == WDOG_RST && !inhibit_q)
    else $error("watchdog expiry did not reset interface");

  full_cycle_c: cover property (state_q == ST_FAST ##1 state_q == ST_DONE);
  recharge_c: cover property (state_q == ST_DONE ##1 state_q == ST_TRICKLE);
  fault_c: cover property (state_q == ST_PRE ##1 state_q == ST_FAULT);
  bias_c: cover property (bat_only && $fell(therm_bias_on));
endmodule

/* File: charge_pkg.sv */
// Constants, register map and state codes of the charge cycle controller
// What this block does
// - Charge starts only with valid input, inhibit clear and thermistor good.
// - Inhibit set, thermistor in window, input valid: battery switch off.
// - Battery supplement of the system rail ignores the inhibit bit.
// - Below short-battery threshold charge at fixed trickle current.
// - Trickle and precharge share one timer, a quarter of fast timer.
// - Between short-battery and precharge exit use programmed precharge current.
// - At precharge exit threshold move to fast charge at fast current.
// - Termination disabled: precharge current is one fifth of fast current.
// - Current at termination level ends charge and sets charge-done flag.
// - Applied regulation target is clamped at the upper voltage limit.
// - After termination battery switch off; input keeps feeding system.
// - Termination only while voltage loop controls fast charge.
// - No termination while input, path or thermal loops are active.
// - After termination, battery at recharge threshold starts new cycle.
// - A recharge cycle resets the safety timers.
// - Falling input deglitched 64 us before entering sleep.
// - Input overvoltage clears only after 30 ms of falling input.
// - Battery switch opens after 60 us below undervoltage lockout, except while charging.
// - Battery-only mode: thermistor bias on 4 ms, off 196 ms.
// - Host watchdog of 40 s, 160 s or off resets the interface.
// - Host interface reset after 500 ms of inactivity.
// - After discharge overcurrent wait 250 ms before reconnecting battery, except to start charging.
package charge_pkg;
  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int SLEEP_DGL_US = 64;
  localparam int SLEEP_DGL_CYC = SLEEP_DGL_US * 1000 / CLK_PERIOD_NS;
  localparam int UVLO_DGL_US = 60;
  localparam int UVLO_DGL_CYC = UVLO_DGL_US * 1000 / CLK_PERIOD_NS;
  localparam int OVP_DGL_MS = 30;
  localparam int OVP_DGL_CYC = OVP_DGL_MS * 1000000 / CLK_PERIOD_NS;
  localparam int THERM_ON_MS = 4;
  localparam int THERM_ON_CYC = THERM_ON_MS * 1000000 / CLK_PERIOD_NS;
  localparam int THERM_OFF_MS = 196;
  localparam int THERM_OFF_CYC = THERM_OFF_MS * 1000000 / CLK_PERIOD_NS;
  localparam int IDLE_RST_MS = 500;
  localparam int IDLE_RST_CYC = IDLE_RST_MS * 1000000 / CLK_PERIOD_NS;
  localparam int OCP_REC_MS = 250;
  localparam int OCP_REC_CYC = OCP_REC_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [63:0] NS_PER_S = 64'd1000000000;
  localparam logic [63:0] CLK_NS64 = 64'd20;
  localparam logic [63:0] WDOG_MIN_S = 64'd40;
  localparam logic [63:0] WDOG_MIN_CYC = WDOG_MIN_S * NS_PER_S / CLK_NS64;
  localparam logic [63:0] WDOG_NOM_S = 64'd160;
  localparam logic [63:0] WDOG_NOM_CYC = WDOG_NOM_S * NS_PER_S / CLK_NS64;
  // Safety timer step: setting n gives (n+1) steps
  localparam logic [63:0] SAFETY_STEP_MIN = 64'd180;
  localparam logic [63:0] SAFETY_STEP_CYC =
    SAFETY_STEP_MIN * 64'd60 * NS_PER_S / CLK_NS64;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] FAST_CUR_OFS = 8'h04;
  localparam logic [7:0] PRE_CUR_OFS = 8'h08;
  localparam logic [7:0] VREG_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] APPLIED_OFS = 8'h14;
  // Control fields
  localparam int CTRL_INHIBIT_BIT = 0;
  localparam int CTRL_TERM_DIS_BIT = 1;
  localparam int CTRL_WDOG_LSB = 2;
  localparam int CTRL_SAFETY_LSB = 4;
  localparam logic [1:0] WDOG_OFF = 2'h0;
  localparam logic [1:0] WDOG_MIN = 2'h1;
  localparam logic [1:0] WDOG_NOM = 2'h2;
  // Reset values
  localparam logic [1:0] WDOG_RST = 2'h2;
  localparam logic [1:0] SAFETY_RST = 2'h0;
  localparam logic [9:0] FAST_CUR_RST = 10'h064;
  localparam logic [9:0] PRE_CUR_RST = 10'h014;
  localparam logic [12:0] VREG_RST = 13'h1068;
  // Current codes in mA, voltages in mV
  localparam logic [9:0] TRICKLE_CUR = 10'h005;
  localparam logic [9:0] CUR_DIV = 10'h005;
  localparam logic [12:0] VREG_MAX_MV = 13'h122A;

  // ==========================================================================
  // Charge states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_TRICKLE = 3'b001,
    ST_PRE = 3'b010,
    ST_FAST = 3'b011,
    ST_DONE = 3'b100,
    ST_FAULT = 3'b101
  } chg_state_t;
endpackage

/* File: dgl_if.sv */
// Condition and qualified result between a user and a deglitch timer
`timescale 1ns/100ps
interface dgl_if;
  logic cond;
  logic done;
  modport user(output cond, input done);
  modport timer(input cond, output done);
endinterface

/* File: hold_timer.sv */
// Deglitch timer: done rises after cond has held for CYC clock edges
`timescale 1ns/100ps
module hold_timer #(
  parameter int CYC = 16
) (
  input wire logic mclk,
  input wire logic reset,
  dgl_if.timer dg
);
  localparam int W = $clog2(CYC + 1);
  localparam logic [W-1:0] LAST = W'(CYC - 1);

  logic [W-1:0] cnt_q;
  logic done_q;

  // ==========================================================================
  // Count consecutive cycles of cond; any drop restarts the count
  always_ff @(posedge mclk) begin
    if (reset || !dg.cond) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else if (cnt_q == LAST) begin
      done_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  assign dg.done = done_q;

  hold_count_a: assert property (@(posedge mclk) disable iff (reset)
    $rose(done_q) |-> $past(dg.cond) && cnt_q == LAST)
    else $error("deglitch done without full hold");
endmodule

/* File: battery_model.sv */
// Single-cell battery and regulation-loop model for the charge controller
`timescale 1ns/100ps
module battery_model #(
  parameter int SHORT_MV = 3000,
  parameter int EXIT_MV = 3300,
  parameter int RCH_MV = 4100,
  parameter int UVLO_MV = 2500
) (
  input wire logic mclk,
  input wire logic freeze,
  input wire logic load_en,
  input wire logic [12:0] load_mv,
  input wire logic battery_switch_on,
  input wire logic [9:0] charge_current,
  input wire logic [12:0] vreg_applied,
  output logic vbat_below_short,
  output logic vbat_below_exit,
  output logic vbat_below_recharge,
  output logic vbat_below_uvlo,
  output logic cur_at_termination,
  output logic cv_loop_active
);
  logic [12:0] vbat_q;
  initial vbat_q = 13'h0AF0;
  // Cell climbs 1 mV a cycle while charge current flows
  always @(posedge mclk) begin
    if (load_en) begin
      vbat_q <= load_mv;
    end else if (!freeze && battery_switch_on && charge_current != 10'h000
                 && vbat_q < vreg_applied) begin
      vbat_q <= vbat_q + 13'h0001;
    end
  end
  assign vbat_below_short = int'(vbat_q) < SHORT_MV;
  assign vbat_below_exit = int'(vbat_q) < EXIT_MV;
  assign vbat_below_recharge = int'(vbat_q) < RCH_MV;
  assign vbat_below_uvlo = int'(vbat_q) < UVLO_MV;
  // Voltage loop takes over at the target and the current tapers there
  assign cv_loop_active = vbat_q >= vreg_applied;
  assign cur_at_termination = cv_loop_active;
endmodule

/* File: linear_charge_cycle_controller_tb.sv */
// Self-checking testbench of the charge cycle controller
`timescale 1ns/100ps
module linear_charge_cycle_controller_tb import charge_pkg::*;;
  logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, v;
  logic pready, pslverr, vin_valid = 0, vin_ovp = 0, thermistor_ok = 1;
  logic thermistor_in_window = 1, supplement_req = 0, bat_overcurrent = 0;
  logic vin_dyn_active = 0, path_dyn_active = 0, thermal_reg_active = 0;
  logic vbat_below_short, vbat_below_exit, vbat_below_recharge;
  logic vbat_below_uvlo, cur_at_termination, cv_loop_active;
  logic freeze = 0, load_en = 0, battery_switch_on, charge_done;
  logic safety_fault, therm_bias_on, iface_reset;
  logic [12:0] load_mv = 0, vreg_applied;
  logic [9:0] charge_current;
  logic [2:0] charge_state;
  int mismatches = 0, n_tests = 0, ons;
  always #10 mclk = ~mclk;
  charge_cycle_ctrl #(.SAFETY_STEP(64'h0FA0), .WDOG_MIN_LEN(64'h00C8),
    .WDOG_NOM_LEN(64'h0190), .OVP_DGL_LEN(50), .THERM_ON_LEN(32'h0004),
    .THERM_OFF_LEN(32'h0014), .IDLE_RST_LEN(32'h012C),
    .OCP_REC_LEN(32'h001E)) charge_cycle_ctrl_inst (.*);
  battery_model battery_model_inst (.*);
  // ==========================================================================
  // Tasks
  task automatic end_sim();
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    @(posedge mclk);
    for (int i = 0; i < 50 && pready !== 1'b1; i++) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge mclk);
  endtask
  task automatic wait_state(input logic [2:0] s, input int lim);
    for (int i = 0; i < lim && charge_state !== s; i++) @(posedge mclk);
    check(charge_state, s);
  endtask
  task automatic set_vbat(input logic [12:0] mv);
    load_en <= 1;
    load_mv <= mv;
    @(posedge mclk);
    load_en <= 0;
    repeat (3) @(posedge mclk);
  endtask
  // ==========================================================================
  // Tests
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    end_sim();
  end
  initial begin
    v = $urandom(32'hfa93_df66);
    repeat (5) @(posedge mclk);
    reset <= 0;
    @(posedge mclk);
    apb(0, CTRL_OFS, 0);
    check(rd, 32'(WDOG_RST) << CTRL_WDOG_LSB);
    apb(0, FAST_CUR_OFS, 0);
    check(rd, 32'(FAST_CUR_RST));
    apb(0, VREG_OFS, 0);
    check(rd, 32'(VREG_RST));
    apb(0, 8'h20, 0);
    check(err, 1);
    apb(1, STATUS_OFS, '1);
    check(err, 1);
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 32'h122A : (i == 1) ? 32'h122B : 32'($urandom) & 'h1FFF;
      apb(1, VREG_OFS, v);
      repeat (3) @(posedge mclk);
      check(vreg_applied, (v > VREG_MAX_MV) ? VREG_MAX_MV : v);
    end
    apb(1, VREG_OFS, 32'(VREG_RST));
    ons = 0;
    repeat (240) begin
      @(posedge mclk);
      ons += int'(therm_bias_on === 1'b1);
    end
    check(ons, 40);
    vin_valid <= 1;
    apb(1, CTRL_OFS, 32'h0009);
    set_vbat(13'h0C1C);
    repeat (10) @(posedge mclk);
    check(battery_switch_on, 0);
    check(charge_state, ST_IDLE);
    supplement_req <= 1;
    repeat (3) @(posedge mclk);
    check(battery_switch_on, 1);
    supplement_req <= 0;
    set_vbat(13'h0AF0);
    apb(1, CTRL_OFS, 32'h0008);
    wait_state(ST_TRICKLE, 10);
    check(charge_current, TRICKLE_CUR);
    wait_state(ST_PRE, 300);
    check(charge_current, PRE_CUR_RST);
    wait_state(ST_FAST, 400);
    check(charge_current, FAST_CUR_RST);
    wait_state(ST_DONE, 1000);
    check({charge_done, battery_switch_on}, 2'b10);
    for (int k = 0; k < 3; k++) begin
      set_vbat(13'h0FA0);
      wait_state(ST_FAST, 20);
      vin_dyn_active <= (k == 0);
      path_dyn_active <= (k == 1);
      thermal_reg_active <= (k == 2);
      set_vbat(13'h1036);
      repeat (100) @(posedge mclk);
      check(charge_state, ST_FAST);
      vin_dyn_active <= 0;
      path_dyn_active <= 0;
      thermal_reg_active <= 0;
      wait_state(ST_DONE, 10);
    end
    v = 32'($urandom_range(500, 50));
    apb(1, FAST_CUR_OFS, v);
    apb(1, CTRL_OFS, 32'h000A);
    set_vbat(13'h0C1C);
    wait_state(ST_PRE, 20);
    check(charge_current, 10'(v / 5));
    apb(1, CTRL_OFS, 32'h0008);
    vin_valid <= 0;
    freeze <= 1;
    set_vbat(13'h0B54);
    vin_valid <= 1;
    repeat (600) @(posedge mclk);
    set_vbat(13'h0C1C);
    repeat (290) @(posedge mclk);
    check(charge_state, ST_PRE);
    wait_state(ST_FAULT, 200);
    check({safety_fault, battery_switch_on}, 2'b10);
    thermistor_ok <= 0;
    wait_state(ST_IDLE, 5);
    thermistor_ok <= 1;
    wait_state(ST_PRE, 5);
    check(safety_fault, 0);
    vin_ovp <= 1;
    @(posedge mclk);
    vin_ovp <= 0;
    repeat (30) @(posedge mclk);
    check(charge_state, ST_IDLE);
    bat_overcurrent <= 1;
    @(posedge mclk);
    bat_overcurrent <= 0;
    repeat (2) @(posedge mclk);
    check(battery_switch_on, 0);
    wait_state(ST_PRE, 60);
    apb(1, FAST_CUR_OFS, 32'h012C);
    for (int i = 0; i < 320 && iface_reset !== 1'b1; i++) @(posedge mclk);
    check(iface_reset, 1);
    repeat (120) @(posedge mclk);
    apb(0, FAST_CUR_OFS, 0);
    check(rd, 32'(FAST_CUR_RST));
    end_sim();
  end
endmodule
